// file: bench/tso_engine_checker.sv
`timescale 1ns/1ps
module tso_engine_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic dma_rvalid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_hdr_last,
  input wire logic tx_ready,
  input wire logic [15:0] tx_pay_len,
  input wire logic tx_last_frame,
  input wire logic tx_ip_csum,
  input wire logic tx_tcp_csum
);
  logic [15:0] lim;
  logic [3:0] mode;
  logic [15:0] next_lim;
  logic [3:0] next_mode;
  logic wr_hit;
  // shadows assume aw and w are taken together, which the bench always does
  assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_comb begin
    next_lim = lim;
    next_mode = mode;
    if (wr_hit && s_axi_awaddr == tso_pkg::OFS_LIMIT) next_lim = s_axi_wdata[31:16];
    if (wr_hit && s_axi_awaddr == tso_pkg::OFS_MODE) next_mode = s_axi_wdata[19:16];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim <= 16'h0000;
      mode <= 4'h0;
    end else begin
      lim <= next_lim;
      mode <= next_mode;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_dma_hold;
    dma_req && !dma_rvalid |=> dma_req && $stable(dma_addr);
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("fetch request dropped");
  property p_dma_step;
    dma_req && dma_rvalid |=> !dma_req || dma_addr == $past(dma_addr) + tso_pkg::WORD_STEP;
  endproperty
  a_dma_step: assert property (p_dma_step) else $error("fetch address skipped");
  property p_no_refetch;
    tx_valid |-> !dma_req;
  endproperty
  a_no_refetch: assert property (p_no_refetch) else $error("fetch during frame");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_hdr_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("header byte changed");
  property p_full;
    tx_valid && !tx_last_frame |-> tx_pay_len == lim;
  endproperty
  a_full: assert property (p_full) else $error("inner frame not full");
  property p_last;
    tx_valid && tx_last_frame |-> tx_pay_len <= lim && tx_pay_len != 16'h0000;
  endproperty
  a_last: assert property (p_last) else $error("final frame size off");
  property p_csum;
    tx_valid |-> tx_ip_csum == mode[0] && tx_tcp_csum == mode[1];
  endproperty
  a_csum: assert property (p_csum) else $error("checksum enables wrong");
  property p_seg;
    $rose(dma_req) |-> mode[3];
  endproperty
  a_seg: assert property (p_seg) else $error("fetch without segmentation");
endmodule : tso_engine_checker

bind tso_engine tso_engine_checker #(.ADDR_W(ADDR_W)) chk_u (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .dma_req,
  .dma_addr, .dma_rvalid, .tx_valid, .tx_data, .tx_hdr_last, .tx_ready, .tx_pay_len,
  .tx_last_frame, .tx_ip_csum, .tx_tcp_csum);

// file: bench/tso_engine_tb.sv
`timescale 1ns/1ps
module tso_engine_tb;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, tx_ready = 1'b0, tx_done = 1'b0, tx_fail = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_data;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, dma_addr, dma_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, lat = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_req;
  logic dma_rvalid, tx_valid, tx_hdr_last, tx_last_frame, tx_ip_csum, tx_tcp_csum;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] tx_pay_len;
  logic [7:0] proto [0:79];
  logic [7:0] got [0:79];
  int n_mismatch = 0, samples_checked = 0, n_hdr = 0, n_frames = 0;
  tso_engine #(.ADDR_W(8)) dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_req, .dma_addr, .dma_rvalid, .dma_rdata,
    .tx_valid, .tx_data, .tx_hdr_last, .tx_ready, .tx_pay_len, .tx_last_frame, .tx_ip_csum,
    .tx_tcp_csum, .tx_done, .tx_fail);
  tso_host_model host_u (.aclk, .aresetn, .lat, .dma_req, .dma_addr, .dma_rvalid, .dma_rdata);
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    // the mac stalls every other cycle
    // every frame here exceeds 64 bytes, so the mac's padding never applies
    tx_ready <= ~tx_ready;
    if (tx_done) n_hdr <= 0;
    if (tx_valid && tx_ready) begin
      got[n_hdr % 80] <= tx_data;
      n_hdr <= n_hdr + 1;
      if (tx_hdr_last) n_frames <= n_frames + 1;
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_done(output logic [31:0] d);
    logic [1:0] r;
    do axi_rd(tso_pkg::OFS_STAT, d, r); while (d[9] !== 1'b1);
    axi_wr(tso_pkg::OFS_CTRL, 32'h0000_0002, r);
  endtask : wait_done
  // ethernet v2, 20-byte ip and tcp headers, sequence close to wrapping
  task automatic cfg(input logic [3:0] m, input logic [15:0] tot, input logic [15:0] lim,
                     input logic [7:0] l4);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 80; i++) proto[i] = 8'(i * 3 + 1);
    {proto[12], proto[13], proto[14], proto[15], proto[16], proto[17]} =
      {32'h0800_4500, 16'h0028 + lim};
    {proto[18], proto[19], proto[20], proto[21], proto[23]} = {32'h1234_0000, l4};
    {proto[38], proto[39], proto[40], proto[41]} = 32'hFFFF_FFF0;
    {proto[46], proto[47], proto[50], proto[51], proto[52], proto[53]} = 48'h5019_ABCD_0000;
    for (int w = 0; w < 20; w++) begin
      host_u.mem[w] = {proto[4 * w + 3], proto[4 * w + 2], proto[4 * w + 1], proto[4 * w]};
    end
    axi_wr(tso_pkg::OFS_LIMIT, {lim, 16'h0000}, r);
    axi_wr(tso_pkg::OFS_MODE, {12'h000, m, 16'h0000}, r);
    axi_wr(tso_pkg::OFS_BUF, 32'h0000_1000, r);
    axi_wr(tso_pkg::OFS_TOTAL, {tot, 16'h0000}, r);
    axi_rd(tso_pkg::OFS_TOTAL, d, r);
    chk(d, {tot, 16'h0000});
    axi_rd(tso_pkg::OFS_LIMIT, d, r);
    chk(d, {lim, 16'h0000});
    axi_wr(tso_pkg::OFS_CTRL, 32'h0000_0001, r);
  endtask : cfg
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(tso_pkg::OFS_TOTAL, d, r);
    chk(d, 32'h0000_0000);
    axi_wr(8'h40, 32'h1234_5678, r);
    chk({30'h0, r}, {30'h0, tso_pkg::RESP_SLVERR});
    axi_rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, tso_pkg::RESP_SLVERR});
  endtask : t_regs
  task automatic run_seg(input logic [3:0] m, input logic [15:0] tot, input logic [15:0] lim,
                         input int fk);
    logic [31:0] d, seq;
    logic [1:0] r;
    logic [15:0] rem, p;
    logic [7:0] ex [0:79];
    int k, w0, n0;
    w0 = host_u.n_words;
    n0 = n_frames;
    cfg(m, tot, lim, tso_pkg::PROTO_TCP);
    rem = tot;
    seq = 32'hFFFF_FFF0;
    k = 0;
    while (rem != 16'h0000) begin
      p = (rem > lim) ? lim : rem;
      wait (n_frames == n0 + k + 1);
      ex = proto;
      {ex[16], ex[17]} = {proto[16], proto[17]} - (lim - p);
      {ex[18], ex[19]} = {proto[18], proto[19]} + 16'(k);
      {ex[38], ex[39], ex[40], ex[41]} = seq;
      if (rem > lim) ex[47] = 8'h10;
      // one's complement take-away; this checksum never borrows
      if (m[1]) {ex[50], ex[51]} = {proto[50], proto[51]} - (lim - p);
      chk(32'(n_hdr), 32'h0000_0036);
      for (int i = 0; i < 54; i++) chk(32'(got[i]), 32'(ex[i]));
      chk(32'(tx_pay_len), 32'(p));
      chk({30'h0, tx_last_frame, tx_tcp_csum}, {30'h0, rem <= lim, m[1]});
      chk(32'(tx_ip_csum), 32'(m[0]));
      axi_rd(tso_pkg::OFS_STAT, d, r);
      chk(32'(d[9:8]), 32'h0000_0001);
      @(posedge aclk);
      tx_fail <= (k == fk);
      tx_done <= 1'b1;
      @(posedge aclk);
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
      seq = seq + 32'(p);
      rem = rem - p;
      k++;
    end
    wait_done(d);
    chk(32'(d[31:24]), (fk >= 0) ? 32'h0000_0001 : 32'h0000_0000);
    chk(32'(d[10]), 32'h0000_0000);
    chk(32'(host_u.n_words - w0), 32'h0000_0014);
    chk(32'(n_frames - n0), 32'(k));
  endtask : run_seg
  // a request that must not produce frames: no segmentation bit, or not tcp
  task automatic refuse(input logic [3:0] m, input logic [7:0] l4, input int nw);
    logic [31:0] d;
    int w0, n0;
    w0 = host_u.n_words;
    n0 = n_frames;
    cfg(m, 16'h00FA, 16'h0064, l4);
    wait_done(d);
    chk(32'(d[10]), 32'h0000_0001);
    chk(32'(host_u.n_words - w0), 32'(nw));
    chk(32'(n_frames - n0), 32'h0000_0000);
  endtask : refuse
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    run_seg(4'hC, 16'h00FA, 16'h0064, -1);
    lat <= 4'h3;
    run_seg(4'hF, 16'h00B4, 16'h0064, 0);
    refuse(4'h7, tso_pkg::PROTO_TCP, 0);
    refuse(4'hC, 8'h11, 20);
    finish_test();
  end
endmodule : tso_engine_tb

// file: bench/tso_host_model.sv
`timescale 1ns/1ps
module tso_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] lat,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  output logic dma_rvalid = 1'b0,
  output logic [31:0] dma_rdata = 32'h5A5A_A5A5
);
  logic [31:0] mem [0:31];
  logic [3:0] wait_n = 4'h0;
  int n_words = 0;
  always @(posedge aclk) begin
    if (aresetn && dma_req && !dma_rvalid && wait_n >= lat) begin
      dma_rvalid <= 1'b1;
      dma_rdata <= mem[dma_addr[6:2]];
      n_words <= n_words + 1;
    end else begin
      dma_rvalid <= 1'b0;
      // idle data keeps flipping so a stale word is never mistaken for an answer
      dma_rdata <= ~dma_rdata;
    end
    if (!aresetn || !dma_req || dma_rvalid) begin
      wait_n <= 4'h0;
    end else if (wait_n < lat) begin
      wait_n <= wait_n + 4'h1;
    end
  end
endmodule : tso_host_model

// file: inc/tso_pkg.sv
package tso_pkg;
  localparam logic [7:0] OFS_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_BUF = 8'h18;
  localparam logic [7:0] OFS_TOTAL = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  localparam int HALF_LSB = 16;
  localparam int MODE_IPCS = 16;
  localparam int MODE_TCPCS = 17;
  localparam int MODE_PARSE = 18;
  localparam int MODE_SEG = 19;
  localparam int CTRL_START = 0;
  localparam int CTRL_CLR = 1;
  localparam int HDR_BYTES = 80;
  localparam int HDR_WORDS = 20;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [6:0] ETH_TYPE = 7'h0C;
  localparam logic [6:0] ETH_IP = 7'h0E;
  localparam logic [6:0] SNAP_IP = 7'h16;
  localparam logic [6:0] IP_LEN = 7'h02;
  localparam logic [6:0] IP_ID = 7'h04;
  localparam logic [6:0] IP_PROTO = 7'h09;
  localparam logic [6:0] TCP_SEQ = 7'h04;
  localparam logic [6:0] TCP_DOFF = 7'h0C;
  localparam logic [6:0] TCP_FLAGS = 7'h0D;
  localparam logic [6:0] TCP_CSUM = 7'h10;
  localparam logic [7:0] FLAG_FIN = 8'h01;
  localparam logic [7:0] FLAG_PSH = 8'h08;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [15:0] SNAP_MAX = 16'h0600;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_PARSE = 3'b010,
    ST_FRAME = 3'b011,
    ST_EMIT = 3'b100,
    ST_WAIT = 3'b101
  } tso_state_t;
endpackage : tso_pkg

// file: src/tso_engine.sv
`timescale 1ns/1ps
module tso_engine #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic dma_req,
  output logic [31:0] dma_addr,
  input wire logic dma_rvalid,
  input wire logic [31:0] dma_rdata,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_hdr_last,
  input wire logic tx_ready,
  output logic [15:0] tx_pay_len,
  output logic tx_last_frame,
  output logic tx_ip_csum,
  output logic tx_tcp_csum,
  input wire logic tx_done,
  input wire logic tx_fail
);
  logic [31:0] limit_w, mode_w, buf_w, total_w;
  logic aw_h, w_h;
  logic [ADDR_W-1:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic [31:0] next_limit_w, next_mode_w, next_buf_w, next_total_w;
  logic next_aw_h, next_w_h, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_a;
  logic [31:0] next_w_d, next_rdata;
  logic [3:0] next_w_s;
  logic [1:0] next_bresp, next_rresp;
  logic start, clr_done, wr_go;

  tso_pkg::tso_state_t st, next_st;
  logic [7:0] hdr [0:tso_pkg::HDR_BYTES-1];
  logic hdr_we;
  logic [4:0] widx, next_widx;
  logic [6:0] hb, io, to, hlen, next_hb, next_io, next_to, next_hlen;
  logic [15:0] fidx, rem, pay, next_fidx, next_rem, next_pay;
  logic [31:0] seq, next_seq, next_dma_addr;
  logic [7:0] nfail, nframes, next_nfail, next_nframes;
  logic done_f, unsup_f, set_done, next_done_f, next_unsup_f;
  logic next_dma_req, next_tx_valid, next_tx_hdr_last, next_lastf;
  logic [7:0] next_tx_data, pbyte;
  logic [6:0] p_io, p_to;
  logic [15:0] lim, adj, s_len, csum_n;
  logic [16:0] csum_s;

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : wmask

  function automatic logic [15:0] be16(input logic [6:0] i);
    return {hdr[i], hdr[7'(i + 7'h01)]};
  endfunction : be16

  function automatic logic [7:0] sel16(input logic [7:0] cur, input logic [6:0] i,
                                       input logic [6:0] at, input logic [15:0] v);
    logic [7:0] r;
    r = cur;
    if (i == at) r = v[15:8];
    if (i == 7'(at + 7'h01)) r = v[7:0];
    return r;
  endfunction : sel16

  // register bus: address and data may arrive in either order
  assign wr_go = aw_h && w_h && !s_axi_bvalid;
  assign start = wr_go && aw_a == tso_pkg::OFS_CTRL && w_s[0] && w_d[tso_pkg::CTRL_START];
  assign clr_done = wr_go && aw_a == tso_pkg::OFS_CTRL && w_s[0] && w_d[tso_pkg::CTRL_CLR];

  always_comb begin
    next_aw_h = aw_h;
    next_aw_a = aw_a;
    next_w_h = w_h;
    next_w_d = w_d;
    next_w_s = w_s;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_limit_w = limit_w;
    next_mode_w = mode_w;
    next_buf_w = buf_w;
    next_total_w = total_w;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_h = 1'b1;
      next_aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_h = 1'b1;
      next_w_d = s_axi_wdata;
      next_w_s = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (wr_go) begin
      next_aw_h = 1'b0;
      next_w_h = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = tso_pkg::RESP_OKAY;
      // command words are frozen while a block is in flight
      case (aw_a)
        tso_pkg::OFS_LIMIT: if (st == tso_pkg::ST_IDLE) next_limit_w = wmask(limit_w, w_d, w_s);
        tso_pkg::OFS_MODE: if (st == tso_pkg::ST_IDLE) next_mode_w = wmask(mode_w, w_d, w_s);
        tso_pkg::OFS_BUF: if (st == tso_pkg::ST_IDLE) next_buf_w = wmask(buf_w, w_d, w_s);
        tso_pkg::OFS_TOTAL: if (st == tso_pkg::ST_IDLE) next_total_w = wmask(total_w, w_d, w_s);
        tso_pkg::OFS_CTRL, tso_pkg::OFS_STAT: ;
        default: next_bresp = tso_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = tso_pkg::RESP_OKAY;
      case (s_axi_araddr)
        tso_pkg::OFS_LIMIT: next_rdata = limit_w;
        tso_pkg::OFS_MODE: next_rdata = mode_w;
        tso_pkg::OFS_BUF: next_rdata = buf_w;
        tso_pkg::OFS_TOTAL: next_rdata = total_w;
        tso_pkg::OFS_CTRL: next_rdata = '0;
        tso_pkg::OFS_STAT: next_rdata = {nfail, nframes, 5'h00, unsup_f, done_f,
                                         st != tso_pkg::ST_IDLE, 8'h00};
        default: begin
          next_rdata = '0;
          next_rresp = tso_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      aw_a <= '0;
      w_h <= 1'b0;
      w_d <= '0;
      w_s <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tso_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tso_pkg::RESP_OKAY;
      limit_w <= '0;
      mode_w <= '0;
      buf_w <= '0;
      total_w <= '0;
    end else if (ce) begin
      aw_h <= next_aw_h;
      aw_a <= next_aw_a;
      w_h <= next_w_h;
      w_d <= next_w_d;
      w_s <= next_w_s;
      s_axi_awready <= !next_aw_h && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_w_h && !(s_axi_wvalid && s_axi_wready);
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      limit_w <= next_limit_w;
      mode_w <= next_mode_w;
      buf_w <= next_buf_w;
      total_w <= next_total_w;
    end
  end

  assign lim = limit_w[tso_pkg::HALF_LSB +: 16];
  // a process, not assigns: the store is read inside functions, which assigns would not follow
  always_comb begin
    p_io = (be16(tso_pkg::ETH_TYPE) < tso_pkg::SNAP_MAX) ? tso_pkg::SNAP_IP
                                                          : tso_pkg::ETH_IP;
    p_to = 7'(p_io + {hdr[p_io][3:0], 2'b00});
    // every length field shrinks by what the frame lacks against a full one
    adj = 16'(lim - pay);
    s_len = 16'(be16(tso_pkg::ETH_TYPE) - adj);
    csum_s = {1'b0, be16(7'(to + tso_pkg::TCP_CSUM))} + {1'b0, ~adj};
    csum_n = 16'(csum_s[15:0] + {15'h0000, csum_s[16]});
  end

  // patch the stored prototype on the fly as each header byte leaves
  always_comb begin
    pbyte = hdr[hb];
    if (io == tso_pkg::SNAP_IP) pbyte = sel16(pbyte, hb, tso_pkg::ETH_TYPE, s_len);
    pbyte = sel16(pbyte, hb, 7'(io + tso_pkg::IP_LEN),
                  16'(be16(7'(io + tso_pkg::IP_LEN)) - adj));
    pbyte = sel16(pbyte, hb, 7'(io + tso_pkg::IP_ID),
                  16'(be16(7'(io + tso_pkg::IP_ID)) + fidx));
    pbyte = sel16(pbyte, hb, 7'(to + tso_pkg::TCP_SEQ), seq[31:16]);
    pbyte = sel16(pbyte, hb, 7'(to + tso_pkg::TCP_SEQ + 7'h02), seq[15:0]);
    if (hb == 7'(to + tso_pkg::TCP_FLAGS) && !tx_last_frame)
      pbyte = pbyte & ~(tso_pkg::FLAG_FIN | tso_pkg::FLAG_PSH);
    if (tx_tcp_csum)
      pbyte = sel16(pbyte, hb, 7'(to + tso_pkg::TCP_CSUM), csum_n);
  end

  always_comb begin
    next_st = st;
    hdr_we = 1'b0;
    next_widx = widx;
    next_hb = hb;
    next_io = io;
    next_to = to;
    next_hlen = hlen;
    next_fidx = fidx;
    next_rem = rem;
    next_pay = pay;
    next_seq = seq;
    next_nfail = nfail;
    next_nframes = nframes;
    next_unsup_f = unsup_f;
    set_done = 1'b0;
    next_dma_req = dma_req;
    next_dma_addr = dma_addr;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_tx_hdr_last = tx_hdr_last;
    next_lastf = tx_last_frame;
    case (st)
      tso_pkg::ST_IDLE: if (start) begin
        next_unsup_f = 1'b0;
        next_nfail = '0;
        next_nframes = '0;
        if (!mode_w[tso_pkg::MODE_SEG] || lim == '0) begin
          next_unsup_f = 1'b1;
          set_done = 1'b1;
        end else begin
          next_widx = '0;
          next_dma_req = 1'b1;
          next_dma_addr = buf_w;
          next_st = tso_pkg::ST_FETCH;
        end
      end
      tso_pkg::ST_FETCH: if (dma_rvalid) begin
        hdr_we = 1'b1;
        next_widx = 5'(widx + 5'h01);
        next_dma_addr = dma_addr + tso_pkg::WORD_STEP;
        if (widx == 5'(tso_pkg::HDR_WORDS - 1)) begin
          next_dma_req = 1'b0;
          next_st = tso_pkg::ST_PARSE;
        end
      end
      tso_pkg::ST_PARSE: begin
        next_io = p_io;
        next_to = p_to;
        next_hlen = 7'(p_to + {hdr[7'(p_to + tso_pkg::TCP_DOFF)][7:4], 2'b00});
        next_seq = {be16(7'(p_to + tso_pkg::TCP_SEQ)), be16(7'(p_to + tso_pkg::TCP_SEQ + 7'h02))};
        next_rem = total_w[tso_pkg::HALF_LSB +: 16];
        next_fidx = '0;
        if (hdr[7'(p_io + tso_pkg::IP_PROTO)] != tso_pkg::PROTO_TCP) begin
          next_unsup_f = 1'b1;
          set_done = 1'b1;
          next_st = tso_pkg::ST_IDLE;
        end else begin
          next_st = tso_pkg::ST_FRAME;
        end
      end
      tso_pkg::ST_FRAME: begin
        next_lastf = rem <= lim;
        next_pay = (rem > lim) ? lim : rem;
        next_hb = '0;
        next_st = tso_pkg::ST_EMIT;
      end
      tso_pkg::ST_EMIT: begin
        if (tx_valid && tx_ready && tx_hdr_last) begin
          next_tx_valid = 1'b0;
          next_tx_hdr_last = 1'b0;
          next_st = tso_pkg::ST_WAIT;
        end else if (!tx_valid || (tx_ready && !tx_hdr_last)) begin
          next_tx_valid = 1'b1;
          next_tx_data = pbyte;
          next_tx_hdr_last = hb == 7'(hlen - 7'h01);
          next_hb = 7'(hb + 7'h01);
        end
      end
      tso_pkg::ST_WAIT: if (tx_done) begin
        if (tx_fail) next_nfail = 8'(nfail + 8'h01);
        next_nframes = 8'(nframes + 8'h01);
        next_seq = seq + {16'h0000, pay};
        next_rem = 16'(rem - pay);
        next_fidx = 16'(fidx + 16'h0001);
        if (tx_last_frame) begin
          set_done = 1'b1;
          next_st = tso_pkg::ST_IDLE;
        end else begin
          next_st = tso_pkg::ST_FRAME;
        end
      end
      default: next_st = tso_pkg::ST_IDLE;
    endcase
    next_done_f = (done_f && !clr_done) || set_done;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= tso_pkg::ST_IDLE;
      widx <= '0;
      hb <= '0;
      io <= '0;
      to <= '0;
      hlen <= '0;
      fidx <= '0;
      rem <= '0;
      pay <= '0;
      seq <= '0;
      nfail <= '0;
      nframes <= '0;
      done_f <= 1'b0;
      unsup_f <= 1'b0;
      dma_req <= 1'b0;
      dma_addr <= '0;
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_hdr_last <= 1'b0;
      tx_pay_len <= '0;
      tx_last_frame <= 1'b0;
      tx_ip_csum <= 1'b0;
      tx_tcp_csum <= 1'b0;
    end else if (ce) begin
      st <= next_st;
      widx <= next_widx;
      hb <= next_hb;
      io <= next_io;
      to <= next_to;
      hlen <= next_hlen;
      fidx <= next_fidx;
      rem <= next_rem;
      pay <= next_pay;
      seq <= next_seq;
      nfail <= next_nfail;
      nframes <= next_nframes;
      done_f <= next_done_f;
      unsup_f <= next_unsup_f;
      dma_req <= next_dma_req;
      dma_addr <= next_dma_addr;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      tx_hdr_last <= next_tx_hdr_last;
      tx_pay_len <= next_pay;
      tx_last_frame <= next_lastf;
      tx_ip_csum <= mode_w[tso_pkg::MODE_IPCS];
      tx_tcp_csum <= mode_w[tso_pkg::MODE_TCPCS];
    end
  end

  // the header store is plain memory, so it keeps no reset
  always_ff @(posedge aclk) begin
    if (ce && hdr_we) begin
      for (int i = 0; i < 4; i++) begin
        hdr[7'({widx, 2'b00} + i)] <= dma_rdata[8*i +: 8];
      end
    end
  end
endmodule : tso_engine
